// >>> rtl/mioad_pkg.sv
package mioad_pkg;

   // active-low chip selects, one bit per device
   typedef struct packed {
      logic eprom_n;
      logic sram_n;
      logic combo_chip_select_n;
      logic keypad_n;
      logic serial_n;
      logic expio_n;
   } mioad_sel_s;

   typedef logic [15:0] mioad_addr_t;

   // reset values
   localparam mioad_sel_s  SEL_IDLE  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam mioad_addr_t ADDR_RST  = 16'h0000;

   // memory decoder input positions and io decoder input positions
   localparam int MEM_SEL_HI = 15;
   localparam int MEM_SEL_LO = 14;
   localparam int IO_SEL_HI  = 7;
   localparam int IO_SEL_LO  = 6;

   // decoder output slots
   localparam logic [1:0] SLOT_0 = 2'h0;
   localparam logic [1:0] SLOT_1 = 2'h1;
   localparam logic [1:0] SLOT_2 = 2'h2;
   localparam logic [1:0] SLOT_3 = 2'h3;

   // window edges of both maps
   localparam mioad_addr_t EPROM_STD_TOP = 16'h3fff;
   localparam mioad_addr_t EPROM_ALT_TOP = 16'h7fff;
   localparam mioad_addr_t SRAM_STD_BASE = 16'h4000;
   localparam mioad_addr_t SRAM_STD_TOP  = 16'hbfff;
   localparam mioad_addr_t SRAM_ALT_BASE = 16'h8000;
   localparam mioad_addr_t COMBO_BASE    = 16'hc000;
   localparam logic [7:0]  IO_COMBO_TOP  = 8'h3f;
   localparam logic [7:0]  IO_KEY_BASE   = 8'h40;
   localparam logic [7:0]  IO_KEY_TOP    = 8'h7f;
   localparam logic [7:0]  IO_SER_BASE   = 8'h80;
   localparam logic [7:0]  IO_SER_TOP    = 8'hbf;
   localparam logic [7:0]  IO_EXP_BASE   = 8'hc0;

endpackage : mioad_pkg

// >>> rtl/mioad_decoder.sv
// Behaviour
// [RULE1] standard map: eprom at 0000-3fff
// [RULE2] alternate map: eprom at 0000-7fff
// [RULE3] standard map: static ram at 4000-bfff
// [RULE4] alternate map: static ram at 8000-ffff
// [RULE5] standard map: combo memory at c000-ffff
// [RULE6] combo io part at io 00-3f
// [RULE7] combo ram mirrors across its window
// [RULE8] alternate map never selects combo memory
// [RULE9] memory decode from two top address bits
// [RULE10] alternate map holds second decoder input low
// [RULE11] io decode from bits 7 and 6
// [RULE12] io/mem indicator enables one decoder each
// [RULE13] selects active low, idle outside range
// [RULE14] keypad select at io 40-7f
// [RULE15] serial select at io 80-bf
// [RULE16] expansion select at io c0-ff
// [RULE17] two 16k outputs merged into ram select
// [RULE18] combo select merges memory and io
// [RULE19] unused address lines pass through unchanged
// [RULE20] static input chooses standard or alternate map
module mioad_decoder (
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   input  wire logic                 ce,
   input  wire mioad_pkg::mioad_addr_t addr,
   input  wire logic                 io_mem,
   input  wire logic                 map_layout_option,
   input  wire logic                 eprom_size_option,
   output      mioad_pkg::mioad_sel_s  chip_sel_n,
   output      mioad_pkg::mioad_addr_t addr_out,
   output      logic                 eprom_pin27
);
   import mioad_pkg::*;

   // 2-to-4 decoder with active-low enable and active-low outputs
   function automatic logic [3:0] dec2to4(input logic en_n, input logic [1:0] code);
      logic [3:0] y;
      y = 4'hf;
      if (!en_n) begin
         y[code] = 1'b0;
      end
      return y;
   endfunction : dec2to4

   logic       mem_en_n;
   logic       io_en_n;
   logic [1:0] mem_code;
   logic [1:0] io_code;
   logic [3:0] mem_y_n;
   logic [3:0] io_y_n;
   mioad_sel_s sel_d;
   mioad_sel_s sel_q;
   mioad_addr_t addr_q;
   logic       pin27_d;
   logic       pin27_q;

   // decoder enables from the io/mem indicator and its inverted copy
   // [RULE12] decoder enable steering
   assign io_en_n  = ~io_mem;
   assign mem_en_n = io_mem;

   // memory decoder looks at the top two address bits; alternate map grounds the lower one
   // [RULE9] top-bit memory decode
   // [RULE10] alternate grounds input
   // [RULE20] map option select
   assign mem_code = {addr[MEM_SEL_HI], addr[MEM_SEL_LO] & ~map_layout_option};
   // [RULE11] io bits decode
   assign io_code  = {addr[IO_SEL_HI], addr[IO_SEL_LO]};
   assign mem_y_n  = dec2to4(mem_en_n, mem_code);
   assign io_y_n   = dec2to4(io_en_n, io_code);

   // chip selects from decoder slots
   // [RULE1] eprom standard window
   // [RULE2] eprom alternate window
   assign sel_d.eprom_n = mem_y_n[SLOT_0];
   // [RULE17] negative-or of slots
   // [RULE3] ram standard window
   // [RULE4] ram alternate window
   assign sel_d.sram_n = mem_y_n[SLOT_1] & mem_y_n[SLOT_2];
   // slot 3 is unreachable in the alternate map, so the combo memory drops out there
   // [RULE18] dual mapped select
   // [RULE5] combo memory window
   // [RULE6] combo io window
   // [RULE8] no combo in alternate
   assign sel_d.combo_chip_select_n = mem_y_n[SLOT_3] & io_y_n[SLOT_0];
   // [RULE14] keypad io window
   assign sel_d.keypad_n = io_y_n[SLOT_1];
   // [RULE15] serial io window
   assign sel_d.serial_n = io_y_n[SLOT_2];
   // [RULE16] expansion io window
   assign sel_d.expio_n  = io_y_n[SLOT_3];

   // eprom pin 27 carries a14 for the 32k part, else tied high
   assign pin27_d = eprom_size_option ? addr[MEM_SEL_LO] : 1'b1;

   // output registers, loaded by reset regardless of ce, otherwise frozen while ce is low
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sel_q   <= SEL_IDLE;
         addr_q  <= ADDR_RST;
         pin27_q <= 1'b1;
      end else if (ce) begin
         sel_q   <= sel_d;
         // [RULE19] address pass-through
         addr_q  <= addr;
         pin27_q <= pin27_d;
      end
   end

   // [RULE7] low bits reach the combo ram
   assign addr_out    = addr_q;
   assign chip_sel_n  = sel_q;
   assign eprom_pin27 = pin27_q;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence live_s;
      resetn && ce;
   endsequence

   a_eprom_std_sel : assert property ( // [RULE1]
      live_s and (!io_mem && !map_layout_option && addr <= EPROM_STD_TOP)
      |=> !chip_sel_n.eprom_n && chip_sel_n.sram_n && chip_sel_n.combo_chip_select_n)
      else $error("eprom not selected in standard map");
   a_eprom_alt_sel : assert property ( // [RULE2]
      live_s and (!io_mem && map_layout_option)
      |=> chip_sel_n.eprom_n == $past(addr[MEM_SEL_HI]))
      else $error("eprom select wrong in alternate map");
   a_sram_std_sel : assert property ( // [RULE3]
      live_s and (!io_mem && !map_layout_option)
      |=> !chip_sel_n.sram_n == ($past(addr) >= SRAM_STD_BASE && $past(addr) <= SRAM_STD_TOP))
      else $error("static ram select wrong in standard map");
   a_sram_alt_sel : assert property ( // [RULE4]
      live_s and (!io_mem && map_layout_option && addr >= SRAM_ALT_BASE)
      |=> !chip_sel_n.sram_n && chip_sel_n.eprom_n)
      else $error("static ram not selected in alternate map");
   a_combo_mem_sel : assert property ( // [RULE5]
      live_s and (!io_mem && !map_layout_option && addr >= COMBO_BASE)
      |=> !chip_sel_n.combo_chip_select_n)
      else $error("combo memory window missed");
   a_combo_alt_off : assert property ( // [RULE8]
      live_s and (!io_mem && map_layout_option) |=> chip_sel_n.combo_chip_select_n)
      else $error("combo selected in alternate map");
   a_combo_io_sel : assert property ( // [RULE6]
      live_s and (io_mem && addr[7:0] <= IO_COMBO_TOP)
      |=> !chip_sel_n.combo_chip_select_n && chip_sel_n.keypad_n && chip_sel_n.eprom_n)
      else $error("combo io window missed");
   a_keypad_io_sel : assert property ( // [RULE14]
      live_s and io_mem
      |=> !chip_sel_n.keypad_n == ($past(addr[7:0]) >= IO_KEY_BASE
                                   && $past(addr[7:0]) <= IO_KEY_TOP))
      else $error("keypad select wrong");
   a_serial_io_sel : assert property ( // [RULE15]
      live_s and (io_mem && addr[7:0] >= IO_SER_BASE && addr[7:0] <= IO_SER_TOP)
      |=> !chip_sel_n.serial_n && chip_sel_n.expio_n)
      else $error("serial select missed");
   a_expio_io_sel : assert property ( // [RULE16]
      live_s and (io_mem && addr[7:0] >= IO_EXP_BASE) |=> !chip_sel_n.expio_n)
      else $error("expansion select missed");
   a_one_hot_sel : assert property ( // [RULE13]
      $countones(~chip_sel_n) <= 1)
      else $error("more than one select active");
   a_mem_io_split : assert property ( // [RULE12]
      live_s and io_mem |=> chip_sel_n.eprom_n && chip_sel_n.sram_n)
      else $error("memory select during io cycle");
   a_addr_pass : assert property ( // [RULE19]
      live_s |=> addr_out == $past(addr))
      else $error("address not passed through");
   a_freeze_ce : assert property (
      resetn && !ce |=> $stable(chip_sel_n) && $stable(addr_out))
      else $error("state moved with ce low");

   // [RULE13] idle after reset
   // reset must park every select high, even with ce low
   a_reset_idle : assert property ( // [RULE13]
      disable iff (1'b0)
      !resetn |=> chip_sel_n == SEL_IDLE && addr_out == ADDR_RST && eprom_pin27)
      else $error("outputs not idle after reset");

   // pin 27 follows the second address bit for the large part
   // a wrong level here would fold the upper half of the eprom
   a_pin27_size : assert property (
      live_s and eprom_size_option |=> eprom_pin27 == $past(addr[MEM_SEL_LO]))
      else $error("pin 27 does not follow address");

   // pin 27 stays high for the small parts
   // the small parts read this pin as a supply or program input
   a_pin27_high : assert property (
      live_s and !eprom_size_option |=> eprom_pin27)
      else $error("pin 27 not high");

   // [RULE4] ram off below alternate base
   // the lower half belongs to the eprom in this map
   a_sram_alt_off : assert property ( // [RULE4]
      live_s and (!io_mem && map_layout_option && addr < SRAM_ALT_BASE)
      |=> chip_sel_n.sram_n)
      else $error("static ram selected below its alternate window");

   // [RULE1] eprom off above standard top
   // a stray eprom select would fight the ram on the data bus
   a_eprom_std_off : assert property ( // [RULE1]
      live_s and (!io_mem && !map_layout_option && addr > EPROM_STD_TOP)
      |=> chip_sel_n.eprom_n)
      else $error("eprom selected above standard window");

   // [RULE5] combo off below its window
   // the combo memory only answers in the top quarter
   a_combo_std_off : assert property ( // [RULE5]
      live_s and (!io_mem && !map_layout_option && addr < COMBO_BASE)
      |=> chip_sel_n.combo_chip_select_n)
      else $error("combo selected below its memory window");

   // [RULE6] combo off above io window
   // the io part of the combo select covers the first quarter only
   a_combo_io_off : assert property ( // [RULE6]
      live_s and (io_mem && addr[7:0] > IO_COMBO_TOP) |=> chip_sel_n.combo_chip_select_n)
      else $error("combo selected above its io window");

   // [RULE15] serial off outside window
   // the serial part must not answer keypad or expansion cycles
   a_serial_io_off : assert property ( // [RULE15]
      live_s and (io_mem && (addr[7:0] < IO_SER_BASE || addr[7:0] > IO_SER_TOP))
      |=> chip_sel_n.serial_n)
      else $error("serial selected outside its window");

   // [RULE16] expansion off below window
   // the expansion space is the last quarter of the io map
   a_expio_io_off : assert property ( // [RULE16]
      live_s and (io_mem && addr[7:0] < IO_EXP_BASE) |=> chip_sel_n.expio_n)
      else $error("expansion selected below its window");

   // [RULE12] io selects off in memory
   // a memory cycle must never strobe an io device
   a_io_off_mem : assert property ( // [RULE12]
      live_s and !io_mem |=> chip_sel_n.keypad_n && chip_sel_n.serial_n && chip_sel_n.expio_n)
      else $error("io select during memory cycle");

   // [RULE13] one memory select low
   // both maps cover the whole memory space with no gap
   a_mem_one_low : assert property ( // [RULE13]
      live_s and !io_mem |=> $countones(~chip_sel_n) == 1)
      else $error("memory cycle without exactly one select");

   // [RULE11] one io select low
   // four quarters of the io map leave no address unclaimed
   a_io_one_low : assert property ( // [RULE11]
      live_s and io_mem |=> $countones(~chip_sel_n) == 1)
      else $error("io cycle without exactly one select");

   // [RULE10] alternate ram by top bit
   // with the second bit grounded only the top bit picks the device
   a_alt_top_bit : assert property ( // [RULE10]
      live_s and (!io_mem && map_layout_option)
      |=> chip_sel_n.sram_n == !$past(addr[MEM_SEL_HI]))
      else $error("alternate ram select ignores top bit");

   // [RULE10] second quarter is eprom
   // in the alternate map the second quarter must fold onto slot 0
   a_alt_second_q : assert property ( // [RULE10]
      live_s and (!io_mem && map_layout_option && addr[MEM_SEL_HI:MEM_SEL_LO] == 2'h1)
      |=> !chip_sel_n.eprom_n && chip_sel_n.sram_n && chip_sel_n.combo_chip_select_n)
      else $error("alternate second quarter not eprom");

   // [RULE17] either middle quarter selects ram
   // the two middle slots together form one 32k window
   a_sram_std_merge : assert property ( // [RULE17]
      live_s and (!io_mem && !map_layout_option && addr[MEM_SEL_HI] != addr[MEM_SEL_LO])
      |=> !chip_sel_n.sram_n)
      else $error("middle quarter missed ram select");

   // [RULE7] combo ram sees low bits
   // every 256-byte page of the window reaches the same cells
   a_combo_mirror : assert property ( // [RULE7]
      live_s and (!io_mem && !map_layout_option && addr[MEM_SEL_HI:MEM_SEL_LO] == 2'h3)
      |=> !chip_sel_n.combo_chip_select_n && addr_out[7:0] == $past(addr[7:0]))
      else $error("combo mirror page lost");

   // [RULE20] map option moves second quarter
   // the option swaps this quarter between ram and eprom
   a_map_option : assert property ( // [RULE20]
      live_s and (!io_mem && addr[MEM_SEL_HI:MEM_SEL_LO] == 2'h1)
      |=> chip_sel_n.eprom_n == !$past(map_layout_option))
      else $error("map option ignored");

   // pin 27 frozen with ce low
   // a moving pin would change the eprom page while frozen
   a_freeze_pin27 : assert property (
      resetn && !ce |=> $stable(eprom_pin27))
      else $error("pin 27 moved with ce low");

   c_eprom_then_sram : cover property (
      live_s and !chip_sel_n.eprom_n ##1 !chip_sel_n.sram_n);
   c_alt_sram : cover property (live_s and map_layout_option && !chip_sel_n.sram_n);
   c_keypad_io : cover property (live_s and !chip_sel_n.keypad_n);
   c_combo_io : cover property (live_s and io_mem ##1 !chip_sel_n.combo_chip_select_n);
   c_ce_freeze : cover property (resetn && !ce ##1 resetn && ce);

endmodule : mioad_decoder

// >>> sim/mioad_bus_model.sv
// processor side: drives address and io/memory indicator one cycle at a time
module mioad_bus_model (
   input  wire logic                   mclk,
   output      mioad_pkg::mioad_addr_t addr,
   output      logic                   io_mem
);
   timeunit 1ns;
   timeprecision 1ps;
   import mioad_pkg::*;

   // bus idles at address zero, memory cycle
   initial begin
      addr   = ADDR_RST;
      io_mem = 1'b0;
   end

   // one bus cycle, launched just after the rising edge
   task automatic drive(input mioad_addr_t a, input logic io);
      @(posedge mclk);
      addr   <= a;
      io_mem <= io;
   endtask : drive
endmodule : mioad_bus_model

// >>> sim/mioad_decoder_bench.sv
module mioad_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mioad_pkg::*;
   logic        mclk, resetn, ce, map_opt, size_opt, io_mem, pin27;
   mioad_addr_t addr, addr_out;
   mioad_sel_s  sel_n;
   int          miscompares, tests_run;

   mioad_bus_model cpu_u (.mclk(mclk), .addr(addr), .io_mem(io_mem));
   mioad_decoder dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr), .io_mem(io_mem),
      .map_layout_option(map_opt), .eprom_size_option(size_opt), .chip_sel_n(sel_n),
      .addr_out(addr_out), .eprom_pin27(pin27));

   // 40 mhz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // expected selects from the address maps
   function automatic mioad_sel_s expect_sel(mioad_addr_t a, logic io, logic alt);
      mioad_sel_s s;
      s = SEL_IDLE;
      if (io) begin
         case (a[7:6])
            2'h0: s.combo_chip_select_n = 1'b0;
            2'h1: s.keypad_n = 1'b0;
            2'h2: s.serial_n = 1'b0;
            default: s.expio_n = 1'b0;
         endcase
      end else if (alt) begin
         if (a[15]) s.sram_n = 1'b0;
         else s.eprom_n = 1'b0;
      end else begin
         case (a[15:14])
            2'h0: s.eprom_n = 1'b0;
            2'h3: s.combo_chip_select_n = 1'b0;
            default: s.sram_n = 1'b0;
         endcase
      end
      return s;
   endfunction : expect_sel

   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : compare

   // one cycle, then all outputs one edge later
   task automatic probe(input mioad_addr_t a, input logic io);
      mioad_sel_s e;
      cpu_u.drive(a, io);
      e = expect_sel(a, io, map_opt);
      @(posedge mclk);
      #1;
      compare({10'h000, sel_n}, {10'h000, e});
      compare(addr_out, a);
      compare({15'h0000, pin27}, {15'h0000, size_opt ? a[14] : 1'b1});
   endtask : probe

   task automatic std_map_test();
      mioad_addr_t pts[8] = '{16'h0000, 16'h3fff, 16'h4000, 16'hbfff,
                              16'hc000, 16'hc1ff, 16'hfd00, 16'hffff};
      map_opt  <= 1'b0;
      size_opt <= 1'b0;
      foreach (pts[i]) probe(pts[i], 1'b0);
      $display("standard map test done");
   endtask : std_map_test

   task automatic alt_map_test();
      mioad_addr_t pts[6] = '{16'h0000, 16'h4000, 16'h7fff, 16'h8000, 16'hc000, 16'hffff};
      map_opt  <= 1'b1;
      size_opt <= 1'b1;
      foreach (pts[i]) probe(pts[i], 1'b0);
      $display("alternate map test done");
   endtask : alt_map_test

   task automatic io_map_test();
      mioad_addr_t pts[8] = '{16'hc000, 16'h123f, 16'h0040, 16'hff7f,
                              16'h0080, 16'h40bf, 16'h00c0, 16'h80ff};
      map_opt <= 1'b0;
      foreach (pts[i]) probe(pts[i], 1'b1);
      probe(16'hc000, 1'b0);
      $display("io map test done");
   endtask : io_map_test

   task automatic ce_reset_test();
      map_opt  <= 1'b0;
      size_opt <= 1'b0;
      probe(16'h4000, 1'b0);
      ce <= 1'b0;
      cpu_u.drive(16'h0000, 1'b0);
      @(posedge mclk);
      #1;
      compare({10'h000, sel_n}, {10'h000, expect_sel(16'h4000, 1'b0, 1'b0)});
      compare(addr_out, 16'h4000);
      ce     <= 1'b1;
      resetn <= 1'b0;
      @(posedge mclk);
      #1;
      compare({10'h000, sel_n}, {10'h000, SEL_IDLE});
      compare(addr_out, ADDR_RST);
      resetn <= 1'b1;
      probe(16'hc0ff, 1'b0);
      $display("ce and reset test done");
   endtask : ce_reset_test

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   // watchdog against a hung run
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      final_report();
   end

   // reset, then the scenarios
   initial begin
      resetn   = 1'b0;
      ce       = 1'b1;
      map_opt  = 1'b0;
      size_opt = 1'b0;
      repeat (16) @(posedge mclk);
      #1;
      compare({10'h000, sel_n}, {10'h000, SEL_IDLE});
      @(posedge mclk);
      resetn <= 1'b1;
      std_map_test();
      alt_map_test();
      io_map_test();
      ce_reset_test();
      final_report();
   end
endmodule : mioad_decoder_bench
